//--- shared/power_sequencer_defines.vh
// Constants for the power button and wake sequencer
// Function
// R1 - Short press ending in soft-off or sleep moves the system to working.
// R2 - Short press in working enters standby only when the OS enabled it.
// R3 - Switch held over six seconds in working or sleep forces soft-off.
// R4 - Switch, RTC, LAN, PME and WAKE requests wake from S1, S3, S4, S5.
// R5 - USB and serial activity wake only from S1 and S3.
// R6 - USB port power is off in S4 and S5.
// R7 - In S3 to S5 only wake-up logic stays powered.
// R8 - Function key during self test starts the remote-assist session.
// R9 - Header button triggers the remote-assist session like the function key; the code takes the header button at any time, not only during self test.
// R10 - Remote-help request raised by the same trigger as remote-assist.
// R11 - Switch debounced; press between four and six seconds changes nothing.
`ifndef POWER_SEQUENCER_DEFINES_VH
`define POWER_SEQUENCER_DEFINES_VH
`define CLOCK_HZ 10000000
`define SHORT_PRESS_MS 4000
`define LONG_PRESS_MS 6000
`define DEBOUNCE_US 10000
`define SHORT_PRESS_CYCLES (`CLOCK_HZ / 1000 * `SHORT_PRESS_MS)
`define LONG_PRESS_CYCLES (`CLOCK_HZ / 1000 * `LONG_PRESS_MS)
`define DEBOUNCE_CYCLES (`CLOCK_HZ / 1000000 * `DEBOUNCE_US)
`define SLEEP_S1 2'd0
`define SLEEP_S3 2'd1
`define SLEEP_S4 2'd2
`endif

//--- hdl/power_button_wake_sequencer.v
// Power button timing, sleep state control and wake source gating
`timescale 1ns/1ps
`include "power_sequencer_defines.vh"
module power_button_wake_sequencer #(
   parameter SHORT_PRESS_CYCLES = `SHORT_PRESS_CYCLES,
   parameter LONG_PRESS_CYCLES = `LONG_PRESS_CYCLES,
   parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
   input wire clock,
   input wire resetn,
   input wire power_switch_n,
   input wire standby_enable,
   input wire sleep_request,
   input wire [1:0] sleep_type,
   input wire off_request,
   input wire rtc_alarm,
   input wire lan_wake,
   input wire pci_pme_n,
   input wire pcie_wake_n,
   input wire usb_activity,
   input wire serial_activity,
   input wire power_on_self_test,
   input wire assist_function_key,
   input wire assist_button_header_n,
   output reg state_working,
   output reg state_s1,
   output reg state_s3,
   output reg state_s4,
   output reg state_soft_off,
   output reg main_power_on,
   output reg wake_logic_power_on,
   output reg usb_port_power_on,
   output reg wake_event,
   output reg remote_assist_start,
   output reg remote_help_request
);
   localparam ST_OFF = 5'b00001;
   localparam ST_WORK = 5'b00010;
   localparam ST_S1 = 5'b00100;
   localparam ST_S3 = 5'b01000;
   localparam ST_S4 = 5'b10000;

   reg [4:0] state;
   reg [4:0] next_state;
   reg sw_stable;
   reg [31:0] debounce_count;
   reg [31:0] press_count;
   reg long_done;

   // Sleep entry target for the requested sleep type; the S5 code lands in soft-off
   function [4:0] sleep_target;
      input [1:0] code;
      begin
         case (code)
            `SLEEP_S1: sleep_target = ST_S1;
            `SLEEP_S3: sleep_target = ST_S3;
            `SLEEP_S4: sleep_target = ST_S4;
            default: sleep_target = ST_OFF;
         endcase
      end
   endfunction

   // Light sources are only trusted while the context is still in RAM
   function wake_allowed;
      input [4:0] st;
      input full;
      input light;
      begin
         wake_allowed = 1'b0;
         if (st[2] | st[3])
            wake_allowed = full | light; // R5
         else if (st[4] | st[0])
            wake_allowed = full; // R4
      end
   endfunction

   // Any of the three sleep states kept by this block
   function is_sleeping;
      input [4:0] st;
      begin
         is_sleeping = st[2] | st[3] | st[4];
      end
   endfunction

   // Main rails only in working and S1; deeper states keep just the wake logic alive
   function main_rails;
      input [4:0] st;
      begin
         main_rails = st[1] | st[2]; // R7
      end
   endfunction

   // USB port power drops in S4 and in soft-off, which doubles as S5
   function usb_rails;
      input [4:0] st;
      begin
         usb_rails = ~(st[4] | st[0]); // R6
      end
   endfunction

   wire sw_raw = ~power_switch_n;
   wire press_end = sw_stable & ~sw_raw & (debounce_count >= DEBOUNCE_CYCLES - 1);
   wire short_release = press_end & (press_count < SHORT_PRESS_CYCLES);
   wire long_hold = sw_stable & ~long_done & (press_count >= LONG_PRESS_CYCLES);
   wire sleeping = is_sleeping(state);
   wire full_wake = rtc_alarm | lan_wake | ~pci_pme_n | ~pcie_wake_n; // R4
   wire light_wake = usb_activity | serial_activity; // R5
   wire wake_now = wake_allowed(state, full_wake, light_wake); // R4 R5

   // One rising-edge detector per assist trigger: index 0 the key, 1 the header button
   wire [1:0] assist_level = {~assist_button_header_n, assist_function_key};
   wire [1:0] assist_gate = {1'b1, power_on_self_test}; // R8 R9
   wire [1:0] assist_rise;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : assist_detect
         reg level_prev;
         // Both idle levels read as zero, so leaving reset cannot fake an edge
         always @(posedge clock or negedge resetn) begin
            if (!resetn)
               level_prev <= 1'b0;
            else
               level_prev <= assist_level[g];
         end
         assign assist_rise[g] = assist_level[g] & ~level_prev & assist_gate[g];
      end
   endgenerate
   wire assist_edge = |assist_rise; // R8 R9

   // Debounce: the raw level must hold for the whole window before it is taken
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sw_stable <= 1'b0;
         debounce_count <= 32'h0;
      end else if (sw_raw == sw_stable) begin
         debounce_count <= 32'h0;
      end else if (debounce_count >= DEBOUNCE_CYCLES - 1) begin
         sw_stable <= sw_raw; // R11
         debounce_count <= 32'h0;
      end else begin
         debounce_count <= debounce_count + 32'h1;
      end
   end

   // Press length counted in clock cycles, saturating at the long limit
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         press_count <= 32'h0;
         long_done <= 1'b0;
      end else if (!sw_stable) begin
         press_count <= 32'h0;
         long_done <= 1'b0;
      end else begin
         if (press_count < LONG_PRESS_CYCLES)
            press_count <= press_count + 32'h1; // R11
         if (long_hold)
            long_done <= 1'b1;
      end
   end

   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (short_release | wake_now)
               next_state = ST_WORK; // R1
         end
         ST_WORK: begin
            if (long_hold | off_request)
               next_state = ST_OFF; // R3
            else if (short_release & standby_enable)
               next_state = ST_S1; // R2
            else if (sleep_request)
               next_state = sleep_target(sleep_type);
         end
         ST_S1: begin
            if (long_hold)
               next_state = ST_OFF; // R3
            else if (short_release | wake_now)
               next_state = ST_WORK; // R1 R4
         end
         ST_S3: begin
            if (long_hold)
               next_state = ST_OFF; // R3
            else if (short_release | wake_now)
               next_state = ST_WORK; // R1 R4
         end
         // A long hold wins over a wake that arrives in the same cycle
         ST_S4: begin
            if (long_hold)
               next_state = ST_OFF; // R3
            else if (short_release | wake_now)
               next_state = ST_WORK; // R1 R4
         end
         default: next_state = ST_OFF;
      endcase
   end

   // Soft-off doubles as S5; the long press is held off any release decision
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= ST_OFF;
         state_working <= 1'b0;
         state_s1 <= 1'b0;
         state_s3 <= 1'b0;
         state_s4 <= 1'b0;
         state_soft_off <= 1'b1;
         main_power_on <= 1'b0;
         wake_logic_power_on <= 1'b1;
         usb_port_power_on <= 1'b0;
         wake_event <= 1'b0;
         remote_assist_start <= 1'b0;
         remote_help_request <= 1'b0;
      end else begin
         state <= next_state;
         state_working <= next_state[1];
         state_s1 <= next_state[2];
         state_s3 <= next_state[3];
         state_s4 <= next_state[4];
         state_soft_off <= next_state[0];
         main_power_on <= main_rails(next_state); // R7
         wake_logic_power_on <= 1'b1; // R7
         usb_port_power_on <= usb_rails(next_state); // R6
         wake_event <= wake_now & sleeping;
         remote_assist_start <= assist_edge; // R8 R9
         remote_help_request <= assist_edge; // R10
      end
   end
endmodule

//--- test/power_button_wake_sequencer_chk.sv
// Port checker for the power button and wake sequencer
`timescale 1ns/1ps
module power_button_wake_sequencer_chk (
   input wire clock, resetn, power_on_self_test, assist_function_key, assist_button_header_n,
   input wire state_working, state_s3, state_s4, state_soft_off, main_power_on,
   input wire usb_port_power_on, wake_logic_power_on, remote_assist_start, remote_help_request
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence pulse; ##[1:3] remote_assist_start; endsequence
   AST_KEY: assert property (power_on_self_test && $rose(assist_function_key) |-> pulse)
      else $error("no pulse");
   AST_BUTTON: assert property ($fell(assist_button_header_n) |-> pulse)
      else $error("no pulse");
   AST_PAIR: assert property (remote_assist_start == remote_help_request)
      else $error("unpaired");
   AST_SINGLE: assert property (remote_assist_start |=> !remote_assist_start)
      else $error("long pulse");
   AST_USB_OFF: assert property (state_s4 || state_soft_off |-> !usb_port_power_on)
      else $error("usb on");
   AST_MAIN_OFF: assert property (state_s3 || state_s4 || state_soft_off |-> !main_power_on)
      else $error("main on");
   AST_WAKE_LOGIC: assert property (wake_logic_power_on) else $error("wake off");
   AST_MAIN_ON: assert property (state_working |-> main_power_on) else $error("main off");
endmodule
bind power_button_wake_sequencer power_button_wake_sequencer_chk chk (.*);

//--- test/front_panel_model.sv
// Front panel switch and assist button model
`timescale 1ns/1ps
module front_panel_model (
   input wire clock,
   output reg power_switch_n = 1'h1,
   output reg assist_button_header_n = 1'h1
);
   // Contacts move only just after an edge, so no press is shorter than asked
   task press(input integer n); begin @(posedge clock); #1 power_switch_n = 1'h0;
      repeat (n) @(posedge clock); #1 power_switch_n = 1'h1;
      // Let the release clear the debouncer before any next press can begin
      repeat (6) @(posedge clock);
      #1; end endtask
   task button; begin @(posedge clock); #1 assist_button_header_n = 1'h0;
      repeat (3) @(posedge clock); #1 assist_button_header_n = 1'h1; end endtask
endmodule

//--- test/power_button_wake_sequencer_tb.sv
// Self-checking bench for the power button and wake sequencer
`timescale 1ns/1ps
module power_button_wake_sequencer_tb;
   reg clock=0, resetn=0, standby_enable=0, sleep_request=0, off_request=0, rtc_alarm=0;
   reg lan_wake=0, pci_pme_n=1, pcie_wake_n=1, usb_activity=0, serial_activity=0;
   reg power_on_self_test=0, assist_function_key=0;
   reg [1:0] sleep_type=2'h2;
   wire power_switch_n, assist_button_header_n, main_power_on, usb_port_power_on, wake_event;
   wire wake_logic_power_on, remote_assist_start, remote_help_request;
   wire [4:0] st;
   integer n_errors=0, comparisons=0, k;
   front_panel_model fp (.clock(clock), .power_switch_n(power_switch_n),
      .assist_button_header_n(assist_button_header_n));
   power_button_wake_sequencer #(.SHORT_PRESS_CYCLES(40), .LONG_PRESS_CYCLES(60),
      .DEBOUNCE_CYCLES(4)) uut (.clock(clock), .resetn(resetn),
      .power_switch_n(power_switch_n), .standby_enable(standby_enable),
      .sleep_request(sleep_request), .sleep_type(sleep_type), .off_request(off_request),
      .rtc_alarm(rtc_alarm), .lan_wake(lan_wake), .pci_pme_n(pci_pme_n),
      .pcie_wake_n(pcie_wake_n), .usb_activity(usb_activity),
      .serial_activity(serial_activity), .power_on_self_test(power_on_self_test),
      .assist_function_key(assist_function_key),
      .assist_button_header_n(assist_button_header_n), .state_working(st[4]),
      .state_s1(st[3]), .state_s3(st[2]), .state_s4(st[1]), .state_soft_off(st[0]),
      .main_power_on(main_power_on), .wake_logic_power_on(wake_logic_power_on),
      .usb_port_power_on(usb_port_power_on), .wake_event(wake_event),
      .remote_assist_start(remote_assist_start), .remote_help_request(remote_help_request));
   initial forever #50 clock = ~clock;
   initial begin #1000000 n_errors++; summarize; end
   task tick; begin @(posedge clock); #1; end endtask
   task chk(input ok); begin comparisons++;
      if (!ok) begin n_errors++; $display("Error %0t: state %h", $time, st); end end endtask
   task wait_st(input [4:0] e); begin repeat (40) if (st !== e) tick;
      chk(st === e); end endtask
   task power_on; begin fp.press(20); wait_st(5'h10); end endtask
   task hold_times; begin fp.press(50); repeat (20) tick; chk(st === 5'h10);
      fp.press(20); repeat (8) tick; chk(st === 5'h10);
      standby_enable = 1; fp.press(20); wait_st(5'h08);
      fp.press(80); wait_st(5'h01); standby_enable = 0; end endtask
   // Each pass wakes S4 from one full source after proving USB and serial are ignored
   task deep_wake; begin for (k = 0; k < 4; k++) begin
      sleep_request = 1; wait_st(5'h02);
      chk(usb_port_power_on === 0 && main_power_on === 0);
      sleep_request = 0; {usb_activity, serial_activity} = 2'h3; repeat (9) tick;
      chk(st === 5'h02 && wake_event === 0);
      {usb_activity, serial_activity, rtc_alarm, lan_wake, pci_pme_n, pcie_wake_n} = 6'h03 ^ (6'h08 >> k);
      wait_st(5'h10);
      chk(wake_event === 1 && usb_port_power_on === 1 && main_power_on === 1);
      {rtc_alarm, lan_wake, pci_pme_n, pcie_wake_n} = 4'h3; end
      sleep_type = 2'h1; sleep_request = 1; wait_st(5'h04); sleep_request = 0;
      chk(main_power_on === 0 && usb_port_power_on === 1);
      usb_activity = 1; wait_st(5'h10); usb_activity = 0;
      sleep_type = 2'h0; sleep_request = 1; wait_st(5'h08); sleep_request = 0;
      chk(main_power_on === 1);
      serial_activity = 1; wait_st(5'h10); serial_activity = 0;
      sleep_type = 2'h3; sleep_request = 1; wait_st(5'h01); sleep_request = 0;
      chk(usb_port_power_on === 0 && main_power_on === 0);
      rtc_alarm = 1; wait_st(5'h10); rtc_alarm = 0; end endtask
   task assist; begin {power_on_self_test, assist_function_key} = 2'h3; tick;
      chk(remote_assist_start === 1 && remote_help_request === 1); tick;
      chk(remote_assist_start === 0);
      {power_on_self_test, assist_function_key} = 2'h0; tick; assist_function_key = 1; tick;
      chk(remote_assist_start === 0); tick; assist_function_key = 0;
      fork fp.button; begin @(posedge clock); tick;
         chk(remote_assist_start === 1 && remote_help_request === 1); end join
      repeat (4) tick; fp.press(80); wait_st(5'h01); end endtask
   task summarize; begin $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish; end endtask
   initial begin repeat (3) tick; resetn = 1;
      power_on; hold_times; power_on; deep_wake; assist; summarize; end
endmodule
